// [logic/hep_ctrl.sv]
`timescale 1ns/1ps
module hep_ctrl #(
  parameter int N_EP        = 8,
  parameter bit OTG_CAPABLE = 1'b1
) (
  input  wire logic                             clk_i,
  input  wire logic                             rst_i,
  input  wire logic                             psel_i,
  input  wire logic                             penable_i,
  input  wire logic                             pwrite_i,
  input  wire logic [7:0]                       paddr_i,
  input  wire logic [31:0]                      pwdata_i,
  output logic      [31:0]                      prdata_o,
  output logic                                  pready_o,
  output logic                                  pslverr_o,
  input  wire logic [1:0][N_EP-1:0][hep_pkg::STAT_W-1:0] ep_stat_set_i,
  output logic      [1:0][N_EP-1:0]             toggle_o,
  output logic      [1:0][N_EP-1:0][1:0]        speed_o,
  output logic      [1:0][N_EP-1:0][14:0]       hub_word_o,
  output logic                                  ep0_ping_en_o,
  output logic      [N_EP-1:0]                  rx_release_o,
  output logic                                  role_host_o,
  input  wire logic                             vbus_fault_in_i,
  input  wire logic                             vbus_low_i,
  output logic                                  vbus_power_en_out_o,
  output logic                                  vbus_power_en_out_oe_n_o
);
  localparam int EPW = (N_EP > 1) ? $clog2(N_EP) : 1;

  // refuse endpoint counts the select field cannot address
  if (N_EP < 2 || N_EP > 16) begin : g_bad_n_ep
    $error("hep_ctrl: N_EP must lie in 2..16");
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  logic                      host_mode;
  logic [EPW-1:0]            sel_ep;
  logic                      sel_dir;
  logic [1:0][N_EP-1:0]      tog;
  logic                      ping_en;
  logic [1:0][N_EP-1:0][1:0] spd;
  hep_pkg::hep_hub_s [1:0][N_EP-1:0] hub;
  logic [1:0][N_EP-1:0][hep_pkg::STAT_W-1:0] stat;
  logic [N_EP-1:0]           release_q;
  hep_pkg::hep_pwrcfg_s      pcfg;
  logic                      pwr_req;
  logic                      sess_req;
  logic                      fault_flag;
  logic                      verr_flag;
  logic [1:0]                flt_sync;
  logic [1:0]                vlow_sync;
  logic [7:0]                low_cnt;
  logic                      wr;
  logic                      setup;
  logic                      fault_now;
  logic                      pwr_on;
  logic [31:0]               next_rdata;
  logic                      next_err;

  // transfer phases; writes land at the access edge
  assign setup    = psel_i & ~penable_i;
  assign wr       = psel_i & penable_i & pwrite_i;
  assign pready_o = 1'b1;

  // role select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_mode <= ~OTG_CAPABLE;
    end else if (wr && hit(paddr_i, hep_pkg::OFF_MODE) && OTG_CAPABLE) begin
      host_mode <= pwdata_i[0];
    end
  end
  assign role_host_o = host_mode;

  // endpoint and direction select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_ep  <= '0;
      sel_dir <= hep_pkg::host_dir_out;
    end else if (wr && hit(paddr_i, hep_pkg::OFF_SEL)) begin
      sel_ep  <= pwdata_i[EPW-1:0];
      sel_dir <= pwdata_i[hep_pkg::SEL_DIR_BIT];
    end
  end

  // forced data toggle; endpoint zero shares one toggle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tog <= '0;
    end else if (wr && hit(paddr_i, hep_pkg::OFF_TOGGLE) && host_mode) begin
      if (sel_ep == '0) begin
        tog[0][0] <= pwdata_i[0];
        tog[1][0] <= pwdata_i[0];
      end else begin
        tog[sel_dir][sel_ep] <= pwdata_i[0];
      end
    end
  end
  assign toggle_o = tog;

  // ping enable, endpoint zero only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ping_en <= hep_pkg::PING_RST;
    end else if (wr && hit(paddr_i, hep_pkg::OFF_PING) && host_mode) begin
      ping_en <= pwdata_i[0];
    end
  end
  assign ep0_ping_en_o = ping_en;

  // speed and hub routing per endpoint direction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      spd <= '0;
      hub <= '0;
    end else if (wr && host_mode) begin
      if (hit(paddr_i, hep_pkg::OFF_SPEED)) begin
        spd[sel_dir][sel_ep] <= pwdata_i[1:0];
      end else if (hit(paddr_i, hep_pkg::OFF_HUB)) begin
        hub[sel_dir][sel_ep].addr <= pwdata_i[hep_pkg::HUB_ADDR_LSB+:7];
        hub[sel_dir][sel_ep].port <= pwdata_i[hep_pkg::HUB_PORT_LSB+:7];
        hub[sel_dir][sel_ep].low_speed <= pwdata_i[hep_pkg::HUB_LS_BIT];
        spd[sel_dir][sel_ep] <= pwdata_i[hep_pkg::HUB_LS_BIT] ?
          hep_pkg::endpoint_speed_low : hep_pkg::endpoint_speed_full;
      end
    end
  end
  assign speed_o = spd;

  // hub words to the transaction engine
  for (genvar d = 0; d < 2; d++) begin : g_dir
    for (genvar e = 0; e < N_EP; e++) begin : g_ep
      assign hub_word_o[d][e] = {hub[d][e].port, 1'b0, hub[d][e].addr};
    end
  end

  // endpoint status: hardware sets, write-one clears, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat <= '0;
    end else begin
      for (int d = 0; d < 2; d++) begin
        for (int e = 0; e < N_EP; e++) begin
          if (wr && hit(paddr_i, hep_pkg::OFF_EPSTAT) && host_mode &&
              d == int'(sel_dir) && e == int'(sel_ep)) begin
            stat[d][e] <= (stat[d][e] &
              ~pwdata_i[hep_pkg::STAT_W-1:0]) | ep_stat_set_i[d][e];
          end else begin
            stat[d][e] <= stat[d][e] | ep_stat_set_i[d][e];
          end
        end
      end
    end
  end

  // receive packet release pulse, only on software acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      release_q <= '0;
    end else begin
      release_q <= '0;
      if (wr && hit(paddr_i, hep_pkg::OFF_DATAACK) && host_mode) begin
        release_q[sel_ep] <= 1'b1;
      end
    end
  end
  assign rx_release_o = release_q;

  // power configuration and requests
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pcfg     <= hep_pkg::PWRCFG_RST;
      pwr_req  <= 1'b0;
      sess_req <= 1'b0;
    end else if (wr && hit(paddr_i, hep_pkg::OFF_PWRCFG)) begin
      pcfg <= pwdata_i[6:0];
    end else if (wr && hit(paddr_i, hep_pkg::OFF_PWRCTL)) begin
      pwr_req  <= pwdata_i[hep_pkg::PWR_REQ_BIT];
      sess_req <= pwdata_i[hep_pkg::SESS_REQ_BIT];
    end
  end

  // pin synchronisers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flt_sync  <= '0;
      vlow_sync <= '0;
    end else begin
      flt_sync  <= {flt_sync[0], vbus_fault_in_i};
      vlow_sync <= {vlow_sync[0], vbus_low_i};
    end
  end

  // fault qualified by polarity and detection enable
  assign fault_now = pcfg.fault_det_en &
    (flt_sync[1] ~^ pcfg.fault_active_high);

  // sticky fault flag, set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_flag <= 1'b0;
    end else if (fault_now) begin
      fault_flag <= 1'b1;
    end else if (wr && hit(paddr_i, hep_pkg::OFF_PWRSTAT) &&
                 pwdata_i[hep_pkg::PST_FAULT_BIT]) begin
      fault_flag <= 1'b0;
    end
  end

  // vbus drop timer; filter ignores drops shorter than the window
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_cnt   <= '0;
      verr_flag <= 1'b0;
    end else begin
      low_cnt <= vlow_sync[1] ? ((low_cnt == 8'hFF) ? low_cnt :
                 low_cnt + 8'h01) : 8'h00;
      if (vlow_sync[1] && (!pcfg.vbus_glitch_filter_en ||
          low_cnt >= 8'(hep_pkg::VBUS_FILT_CYC - 1))) begin
        verr_flag <= 1'b1;
      end else if (wr && hit(paddr_i, hep_pkg::OFF_PWRSTAT) &&
                   pwdata_i[hep_pkg::PST_VERR_BIT]) begin
        verr_flag <= 1'b0;
      end
    end
  end

  // manual request or session request in dual-role builds
  assign pwr_on = (pcfg.session_mode && OTG_CAPABLE) ? sess_req :
                  pwr_req;

  // power-enable pin, fault action overrides while flag stands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vbus_power_en_out_o      <= 1'b0;
      vbus_power_en_out_oe_n_o <= 1'b0;
    end else if (fault_flag && pcfg.fault_det_en &&
                 pcfg.action != hep_pkg::fault_action_none) begin
      unique case (pcfg.action)
        hep_pkg::fault_action_float: begin
          vbus_power_en_out_o      <= 1'b0;
          vbus_power_en_out_oe_n_o <= 1'b1;
        end
        hep_pkg::fault_action_drive_low: begin
          vbus_power_en_out_o      <= 1'b0;
          vbus_power_en_out_oe_n_o <= 1'b0;
        end
        default: begin
          vbus_power_en_out_o      <= 1'b1;
          vbus_power_en_out_oe_n_o <= 1'b0;
        end
      endcase
    end else begin
      vbus_power_en_out_o      <= pwr_on ~^ pcfg.level_high;
      vbus_power_en_out_oe_n_o <= 1'b0;
    end
  end

  // read-back mux, sampled in the setup cycle
  always_comb begin
    next_rdata = '0;
    next_err   = 1'b0;
    unique case (paddr_i)
      hep_pkg::OFF_MODE:    next_rdata[1:0] = {OTG_CAPABLE, host_mode};
      hep_pkg::OFF_SEL: begin
        next_rdata[EPW-1:0] = sel_ep;
        next_rdata[hep_pkg::SEL_DIR_BIT] = sel_dir;
      end
      hep_pkg::OFF_TOGGLE:  next_rdata[0] = tog[sel_dir][sel_ep];
      hep_pkg::OFF_PING:    next_rdata[0] = ping_en;
      hep_pkg::OFF_SPEED:   next_rdata[1:0] = spd[sel_dir][sel_ep];
      hep_pkg::OFF_EPSTAT:
        next_rdata[hep_pkg::STAT_W-1:0] = stat[sel_dir][sel_ep];
      hep_pkg::OFF_HUB: begin
        next_rdata[14:0] = hub_word_o[sel_dir][sel_ep];
        next_rdata[hep_pkg::HUB_LS_BIT] = hub[sel_dir][sel_ep].low_speed;
      end
      hep_pkg::OFF_DATAACK: next_rdata = '0;
      hep_pkg::OFF_PWRCFG:  next_rdata[6:0] = pcfg;
      hep_pkg::OFF_PWRCTL:  next_rdata[1:0] = {sess_req, pwr_req};
      hep_pkg::OFF_PWRSTAT: next_rdata[2:0] =
        {verr_flag, flt_sync[1], fault_flag};
      default:              next_err = 1'b1;
    endcase
  end

  // answer registers, valid in the access cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata_o  <= '0;
      pslverr_o <= 1'b0;
    end else if (setup) begin
      prdata_o  <= pwrite_i ? 32'h0000_0000 : next_rdata;
      pslverr_o <= next_err;
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_wr(logic [7:0] off);
    wr && paddr_i == off && host_mode;
  endsequence

  property p_tog_force;
    s_wr(hep_pkg::OFF_TOGGLE) and (sel_ep != '0) |=>
      tog[$past(sel_dir)][$past(sel_ep)] == $past(pwdata_i[0]);
  endproperty
  a_tog_force: assert property (p_tog_force)
    else $error("toggle not forced");

  property p_tog_ep0;
    s_wr(hep_pkg::OFF_TOGGLE) and (sel_ep == '0) |=>
      tog[0][0] == $past(pwdata_i[0]) && tog[1][0] == tog[0][0];
  endproperty
  a_tog_ep0: assert property (p_tog_ep0)
    else $error("endpoint zero toggle not shared");

  property p_ping;
    s_wr(hep_pkg::OFF_PING) |=> ep0_ping_en_o == $past(pwdata_i[0]);
  endproperty
  a_ping: assert property (p_ping)
    else $error("ping enable not taken");

  property p_stat_clr;
    s_wr(hep_pkg::OFF_EPSTAT) and pwdata_i[0] and
      !ep_stat_set_i[sel_dir][sel_ep][0] |=>
      !stat[$past(sel_dir)][$past(sel_ep)][0];
  endproperty
  a_stat_clr: assert property (p_stat_clr)
    else $error("status bit not cleared");

  property p_hub;
    s_wr(hep_pkg::OFF_HUB) |=>
      hub_word_o[$past(sel_dir)][$past(sel_ep)] ==
      {$past(pwdata_i[14:8]), 1'b0, $past(pwdata_i[6:0])};
  endproperty
  a_hub: assert property (p_hub)
    else $error("hub word not stored");

  property p_hub_spd;
    s_wr(hep_pkg::OFF_HUB) and pwdata_i[hep_pkg::HUB_LS_BIT] |=>
      spd[$past(sel_dir)][$past(sel_ep)] == hep_pkg::endpoint_speed_low;
  endproperty
  a_hub_spd: assert property (p_hub_spd)
    else $error("low speed not recorded");

  property p_release;
    s_wr(hep_pkg::OFF_DATAACK) |=> rx_release_o[$past(sel_ep)] ##1
      rx_release_o == '0 ||
      $past(wr && paddr_i == hep_pkg::OFF_DATAACK && host_mode);
  endproperty
  a_release: assert property (p_release)
    else $error("release pulse wrong");

  property p_no_release;
    !$past(wr && paddr_i == hep_pkg::OFF_DATAACK && host_mode) |->
      rx_release_o == '0;
  endproperty
  a_no_release: assert property (p_no_release)
    else $error("release without acknowledge");

  property p_fault_flag;
    fault_now |=> fault_flag;
  endproperty
  a_fault_flag: assert property (p_fault_flag)
    else $error("fault flag not set");

  property p_no_det;
    !pcfg.fault_det_en && !fault_flag |=> !fault_flag;
  endproperty
  a_no_det: assert property (p_no_det)
    else $error("fault seen while detection off");

  property p_float;
    fault_flag && pcfg.fault_det_en &&
      pcfg.action == hep_pkg::fault_action_float && !wr
      |=> vbus_power_en_out_oe_n_o;
  endproperty
  a_float: assert property (p_float)
    else $error("power pin not floated on fault");

  sequence s_manual_on;
    !pcfg.session_mode && pwr_req && !fault_flag && !wr;
  endsequence
  property p_manual;
    s_manual_on |=> vbus_power_en_out_o == $past(pcfg.level_high) &&
      !vbus_power_en_out_oe_n_o;
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual power level wrong");

  property p_mode;
    wr && paddr_i == hep_pkg::OFF_MODE |=>
      role_host_o == (OTG_CAPABLE ? $past(pwdata_i[0]) : $past(host_mode));
  endproperty
  a_mode: assert property (p_mode)
    else $error("role not switched");

  property p_filter;
    $rose(verr_flag) && pcfg.vbus_glitch_filter_en |->
      low_cnt >= 8'(hep_pkg::VBUS_FILT_CYC);
  endproperty
  a_filter: assert property (p_filter)
    else $error("short drop reported");
endmodule : hep_ctrl

// [logic/hep_pkg.sv]
// Functional notes
// - host mode: software forces endpoint toggle, 0 gives DATA0, 1 DATA1
// - endpoint zero toggle forcing ignores direction; one shared toggle
// - ping on: ping tokens in high-speed control data/status phases
// - ping enable exists only for control endpoint zero
// - separate low/full/high speed per IN and OUT half of each endpoint
// - status clear clears exactly the named bits, read-back layout
// - per endpoint direction hub word: address bits 0-6, port bits 8-14
// - hub word read-back follows the selected direction
// - hub word write also records downstream speed, optional low-speed
// - dual-role controller switches to host role when software commands it
// - fault input is active low or active high by configured polarity
// - on fault, power-enable pin: no action, float, drive low or drive high
// - manual mode: power pin to configured active level on enable request
// - session mode, dual-role only: active level while session requested
// - glitch filter on: short VBUS drops do not report a VBUS error
// - power disable request deasserts the power-enable pin
// - power enable request asserts the power-enable pin
// - software acknowledges read receive data; packet released only then
// - detection can be switched off; then no fault is seen or acted on
package hep_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_MODE    = 8'h00;
  localparam logic [7:0] OFF_SEL     = 8'h04;
  localparam logic [7:0] OFF_TOGGLE  = 8'h08;
  localparam logic [7:0] OFF_PING    = 8'h0C;
  localparam logic [7:0] OFF_SPEED   = 8'h10;
  localparam logic [7:0] OFF_EPSTAT  = 8'h14;
  localparam logic [7:0] OFF_HUB     = 8'h18;
  localparam logic [7:0] OFF_DATAACK = 8'h1C;
  localparam logic [7:0] OFF_PWRCFG  = 8'h20;
  localparam logic [7:0] OFF_PWRCTL  = 8'h24;
  localparam logic [7:0] OFF_PWRSTAT = 8'h28;
  // field positions
  localparam int SEL_DIR_BIT   = 8;
  localparam int HUB_ADDR_LSB  = 0;
  localparam int HUB_PORT_LSB  = 8;
  localparam int HUB_LS_BIT    = 16;
  localparam int PWR_REQ_BIT   = 0;
  localparam int SESS_REQ_BIT  = 1;
  localparam int PST_FAULT_BIT = 0;
  localparam int PST_RAW_BIT   = 1;
  localparam int PST_VERR_BIT  = 2;
  localparam int STAT_W        = 8;
  // direction select
  localparam logic host_dir_out = 1'b0;
  localparam logic host_dir_in  = 1'b1;
  // speed codes
  localparam logic [1:0] endpoint_speed_full = 2'h0;
  localparam logic [1:0] endpoint_speed_low  = 2'h1;
  localparam logic [1:0] endpoint_speed_high = 2'h2;
  // fault action codes
  localparam logic [1:0] fault_action_none       = 2'h0;
  localparam logic [1:0] fault_action_float      = 2'h1;
  localparam logic [1:0] fault_action_drive_low  = 2'h2;
  localparam logic [1:0] fault_action_drive_high = 2'h3;
  // reset values
  localparam logic       PING_RST = 1'b1;
  localparam logic [6:0] PWRCFG_RST = 7'h00;
  // glitch filter time and rate
  localparam int VBUS_FILT_NS = 500;
  localparam int CLK_MHZ      = 40;
  localparam int VBUS_FILT_CYC = (VBUS_FILT_NS * CLK_MHZ + 999) / 1000;

  // power configuration word, bit 0 first from the bottom
  typedef struct packed {
    logic       fault_det_en;
    logic       vbus_glitch_filter_en;
    logic       session_mode;
    logic       level_high;
    logic [1:0] action;
    logic       fault_active_high;
  } hep_pwrcfg_s;

  // hub routing word as kept per endpoint direction
  typedef struct packed {
    logic       low_speed;
    logic [6:0] port;
    logic [6:0] addr;
  } hep_hub_s;
endpackage : hep_pkg

// [bench/hep_vbus_model.sv]
`timescale 1ns/1ps
// external power switch: reports faults and vbus droop, feeds the supply
module hep_vbus_model (
  input  wire logic clk_i,
  input  wire logic power_en_i,
  input  wire logic power_oe_n_i,
  input  wire logic fault_cmd_i,
  input  wire logic fault_pol_i,
  input  wire logic droop_cmd_i,
  output logic      vbus_fault_in_o,
  output logic      vbus_low_o,
  output logic      supply_on_o
);
  // a floated enable pin is pulled down, so the supply stays off
  assign supply_on_o = !power_oe_n_i && power_en_i;
  // pins change only after clock edges, fault shown at its active level
  always_ff @(posedge clk_i) begin
    vbus_fault_in_o <= fault_cmd_i ? fault_pol_i : !fault_pol_i;
    vbus_low_o      <= droop_cmd_i;
  end
endmodule : hep_vbus_model

// [bench/hep_ctrl_test.sv]
`timescale 1ns/1ps
module hep_ctrl_test;
  typedef struct {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
    logic        err;
  } hep_row_s;
  logic                       clk_i = 1'b0;
  logic                       rst_i = 1'b1;
  logic                       psel = 1'b0;
  logic                       penable = 1'b0;
  logic                       pwrite = 1'b0;
  logic [7:0]                 paddr = 8'h00;
  logic [31:0]                pwdata = 32'h0;
  logic [31:0]                prdata;
  logic                       pready;
  logic                       pslverr;
  logic [1:0][7:0][7:0]       stat_set = '0;
  logic [1:0][7:0]            toggle;
  logic [1:0][7:0][1:0]       speed;
  logic [1:0][7:0][14:0]      hub;
  logic                       ping_en;
  logic [7:0]                 release_rx;
  logic                       role;
  logic                       fault_pin;
  logic                       vbus_low;
  logic                       pwr_pin;
  logic                       pwr_oe_n;
  logic                       fault_cmd = 1'b0;
  logic                       fault_pol = 1'b1;
  logic                       droop = 1'b0;
  logic                       supply;
  int                         n_errors = 0;
  int                         samples_checked = 0;
  logic [31:0]                r;
  int                         hits;
  hep_row_s                   rows [7];

  // 40 MHz clock
  always #12.5 clk_i = !clk_i;

  hep_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .ep_stat_set_i(stat_set), .toggle_o(toggle),
    .speed_o(speed), .hub_word_o(hub), .ep0_ping_en_o(ping_en),
    .rx_release_o(release_rx), .role_host_o(role),
    .vbus_fault_in_i(fault_pin), .vbus_low_i(vbus_low),
    .vbus_power_en_out_o(pwr_pin), .vbus_power_en_out_oe_n_o(pwr_oe_n));

  hep_vbus_model sw (.clk_i(clk_i), .power_en_i(pwr_pin),
    .power_oe_n_i(pwr_oe_n), .fault_cmd_i(fault_cmd),
    .fault_pol_i(fault_pol), .droop_cmd_i(droop),
    .vbus_fault_in_o(fault_pin), .vbus_low_o(vbus_low),
    .supply_on_o(supply));

  // one compare, counted and reported
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // apb transfer entered at a rising edge; waits for pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  // read and compare in one step
  task rdc(input string name, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(name, r, e);
  endtask : rdc

  task tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  task end_of_test;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // watchdog
  initial begin
    #(25 * 20000);
    n_errors++;
    end_of_test();
  end

  initial begin
    rows[0] = '{hep_pkg::OFF_SEL, 32'h103, 32'h103, 1'b0};
    rows[1] = '{hep_pkg::OFF_SPEED, 32'h2, 32'h2, 1'b0};
    rows[2] = '{hep_pkg::OFF_HUB, 32'h10A05, 32'h10A05, 1'b0};
    rows[3] = '{hep_pkg::OFF_PING, 32'h0, 32'h0, 1'b0};
    rows[4] = '{hep_pkg::OFF_PWRCFG, 32'h7F, 32'h7F, 1'b0};
    rows[5] = '{hep_pkg::OFF_MODE, 32'h1, 32'h3, 1'b0};
    rows[6] = '{8'h40, 32'h5, 32'h0, 1'b1};
    tick(10);
    rst_i <= 1'b0;
    tick(1);
    chk("ping_rst", 32'(ping_en), 32'h1);
    chk("role_rst", 32'(role), 32'h0);
    wr(hep_pkg::OFF_TOGGLE, 32'h1);
    chk("toggle_dev", 32'(toggle), 32'h0);
    wr(hep_pkg::OFF_MODE, 32'h1);
    chk("role", 32'(role), 32'h1);
    // register cases
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rdc("row", rows[i].a, rows[i].e);
      chk("row_err", 32'(pslverr), 32'(rows[i].err));
      chk("row_rdy", 32'(pready), 32'h1);
    end
    chk("ping", 32'(ping_en), 32'h0);
    chk("speed_in", 32'(speed[1][3]), 32'(hep_pkg::endpoint_speed_low));
    chk("speed_out", 32'(speed[0][3]), 32'(hep_pkg::endpoint_speed_full));
    chk("hub", 32'(hub[1][3]), 32'h0A05);
    wr(hep_pkg::OFF_SEL, 32'h003);
    rdc("hub_out", hep_pkg::OFF_HUB, 32'h0);
    // endpoint zero forcing hits both directions
    wr(hep_pkg::OFF_SEL, 32'h000);
    wr(hep_pkg::OFF_TOGGLE, 32'h1);
    chk("tog0", 32'(toggle[1][0] & toggle[0][0]), 32'h1);
    wr(hep_pkg::OFF_SEL, 32'h105);
    wr(hep_pkg::OFF_TOGGLE, 32'h1);
    chk("tog5", 32'({toggle[1][5], toggle[0][5]}), 32'h2);
    wr(hep_pkg::OFF_TOGGLE, 32'h0);
    chk("tog5_0", 32'(toggle[1][5]), 32'h0);
    // status set by the core, cleared bit by bit
    stat_set[1][5] <= 8'hA5;
    tick(1);
    stat_set <= '0;
    tick(1);
    rdc("stat", hep_pkg::OFF_EPSTAT, 32'hA5);
    wr(hep_pkg::OFF_EPSTAT, 32'h21);
    rdc("stat_clr", hep_pkg::OFF_EPSTAT, 32'h84);
    // packet released once per acknowledge, only on ep 5
    hits = 0;
    chk("rel_idle", 32'(release_rx), 32'h0);
    fork
      wr(hep_pkg::OFF_DATAACK, 32'h1);
      repeat (8) begin
        @(posedge clk_i);
        if (release_rx === 8'h20) hits++;
        else if (release_rx !== 8'h00) hits += 10;
      end
    join
    chk("release", 32'(hits), 32'h1);
    // manual enable at both active levels
    for (int lvl = 0; lvl < 2; lvl++) begin
      wr(hep_pkg::OFF_PWRCFG, 32'(lvl * 8 + 1));
      wr(hep_pkg::OFF_PWRCTL, 32'h1);
      tick(3);
      chk("pwr_on", 32'(pwr_pin), 32'(lvl));
      wr(hep_pkg::OFF_PWRCTL, 32'h0);
      tick(3);
      chk("pwr_off", 32'(pwr_pin), 32'(1 - lvl));
    end
    wr(hep_pkg::OFF_PWRCFG, 32'h19);
    wr(hep_pkg::OFF_PWRCTL, 32'h2);
    tick(3);
    chk("sess_on", 32'(supply), 32'h1);
    wr(hep_pkg::OFF_PWRCTL, 32'h0);
    tick(3);
    chk("sess_off", 32'(supply), 32'h0);
    // every fault action, polarity alternating
    for (int a = 0; a < 4; a++) begin
      fault_pol <= 1'(a % 2);
      wr(hep_pkg::OFF_PWRCFG, 32'(8'h48 + a * 2 + a % 2));
      wr(hep_pkg::OFF_PWRCTL, 32'h1);
      wr(hep_pkg::OFF_PWRSTAT, 32'h5);
      tick(3);
      chk("flt_pre", 32'(supply), 32'h1);
      fault_cmd <= 1'b1;
      tick(8);
      chk("flt_sup", 32'(supply), 32'(a == 0 || a == 3));
      chk("flt_oe", 32'(pwr_oe_n), 32'(a == 1));
      fault_cmd <= 1'b0;
      tick(6);
      // idle pin sits at the inverse of the fault level
      rdc("flag", hep_pkg::OFF_PWRSTAT, 32'((1 - a % 2) * 2 + 1));
      wr(hep_pkg::OFF_PWRSTAT, 32'h1);
      tick(4);
      rdc("flag_clr", hep_pkg::OFF_PWRSTAT, 32'((1 - a % 2) * 2));
      chk("flt_end", 32'(supply), 32'h1);
    end
    // detection off: fault ignored
    fault_pol <= 1'b1;
    wr(hep_pkg::OFF_PWRCFG, 32'h0D);
    fault_cmd <= 1'b1;
    tick(8);
    chk("nodet", 32'(supply), 32'h1);
    rdc("nodet_flag", hep_pkg::OFF_PWRSTAT, 32'h2);
    fault_cmd <= 1'b0;
    // droops: short unfiltered, short filtered, long filtered
    for (int k = 0; k < 3; k++) begin
      wr(hep_pkg::OFF_PWRCFG, (k == 0) ? 32'h09 : 32'h29);
      wr(hep_pkg::OFF_PWRSTAT, 32'h4);
      droop <= 1'b1;
      tick((k == 2) ? 30 : 5);
      droop <= 1'b0;
      tick(6);
      rdc("verr", hep_pkg::OFF_PWRSTAT, (k == 1) ? 32'h0 : 32'h4);
    end
    // mid-run reset returns the defaults
    rst_i <= 1'b1;
    tick(2);
    rst_i <= 1'b0;
    tick(1);
    chk("ping_rst2", 32'(ping_en), 32'h1);
    chk("role_rst2", 32'(role), 32'h0);
    chk("tog_rst2", 32'(toggle), 32'h0);
    end_of_test();
  end
endmodule : hep_ctrl_test
